// File: core/sspc_pkg.sv
// constants for the serial port pin control block
package sspc_pkg;
    localparam int         ADR_W         = 5;
    localparam logic [4:0] OFS_CTRL      = 5'h00;
    localparam logic [4:0] OFS_STAT      = 5'h04;
    localparam logic [4:0] OFS_DATA      = 5'h08;
    localparam logic [4:0] OFS_PDIR      = 5'h0c;
    localparam logic [4:0] OFS_PDAT      = 5'h10;
    localparam logic [4:0] OFS_PIN       = 5'h14;
    localparam logic [4:0] OFS_EVT       = 5'h18;
    localparam logic [4:0] OFS_MASK      = 5'h1c;
    localparam int         CTRL_EN_BIT   = 6;
    localparam int         CTRL_MS_BIT   = 4;
    localparam int         STAT_DONE_BIT = 7;
    localparam int         STAT_COLL_BIT = 6;
    localparam int         EVT_DONE_BIT  = 0;
    localparam int         EVT_COLL_BIT  = 1;
    localparam int         PB_SCK_BIT    = 7;
    localparam int         PB_SDI_BIT    = 6;
    localparam int         PB_SDO_BIT    = 5;
    localparam logic [7:0] CTRL_RST      = 8'h00;
    localparam logic [7:0] PB_RST        = 8'h00;
    localparam logic [1:0] EVT_RST       = 2'h0;
    localparam logic [2:0] BIT_LAST      = 3'h7;
    localparam int         CLK_MHZ       = 100;
    localparam int         SCK_HALF_NS   = 60;
    localparam int         SCK_HALF_CYC  = (SCK_HALF_NS * CLK_MHZ) / 1000;
    localparam logic [7:0] SCK_HALF_TOP  = 8'(SCK_HALF_CYC - 1);
endpackage

// File: core/sspc_sync.sv
// two-flop synchroniser for the port pins
`timescale 1ns/100ps
module sspc_sync #(
    parameter int W = 3
) (
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    input  wire logic [W-1:0] async_i,
    output logic      [W-1:0] sync_o
);
    logic [W-1:0] meta_q;

    for (genvar i = 0; i < W; i++) begin : g_bit
        always_ff @(posedge clk_i) begin
            if (rst_i) begin
                meta_q[i] <= 1'b0;
                sync_o[i] <= 1'b0;
            end else begin
                meta_q[i] <= async_i[i];
                sync_o[i] <= meta_q[i];
            end
        end
    end
endmodule

// File: core/sspc_top.sv
// serial port with port b pin ownership, flags and wishbone registers
// Behaviour
// - setting the enable bit makes the port own the three pins, clearing it gives them back to plain i/o.
// - with the port enabled, a zero in the out-pin direction bit turns the out pin driver off.
// - master select at zero gives slave mode, where the clock pin is an input.
// - setting the enable bit loads the direction register: in pin input, out pin output, clock by mode.
// - clearing the enable bit leaves direction and data registers as the serial function left them.
// - the done flag sets on the eighth rising serial clock edge of a transfer, started by a master mode data write or the first slave mode rising edge.
// - a set done flag does not block new transfers.
// - the done flag clears on a status read with it set followed by a data access, and on reset.
// - the collision flag sets when the data register is accessed during a transfer.
// - the collision flag clears by the same status read and data access sequence.
// - master select at one gives master mode, where the clock pin drives the shift clock.
// - in master mode a data register write loads the byte and starts shifting it out.
//
// The placing of the registers and register access over Wishbone were chosen for this implementation.
`timescale 1ns/100ps
module sspc_top
    import sspc_pkg::*;
(
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    input  wire logic             cyc_i,
    input  wire logic             stb_i,
    input  wire logic             we_i,
    input  wire logic [ADR_W-1:0] adr_i,
    input  wire logic [3:0]       sel_i,
    input  wire logic [31:0]      dat_i,
    output logic      [31:0]      dat_o,
    output logic                  ack_o,
    output logic                  irq_o,
    input  wire logic             serial_clock_pin_i,
    output logic                  serial_clock_pin_o,
    output logic                  serial_clock_pin_oe_o,
    input  wire logic             serial_in_pin_i,
    output logic                  serial_in_pin_o,
    output logic                  serial_in_pin_oe_o,
    input  wire logic             serial_out_pin_i,
    output logic                  serial_out_pin_o,
    output logic                  serial_out_pin_oe_o
);
    logic [7:0] serial_control_q;
    logic [7:0] port_b_direction_reg_q;
    logic [7:0] port_b_data_q;
    logic [7:0] serial_shift_data_q;
    logic       transfer_done_flag_q;
    logic       access_collision_flag_q;
    logic       clear_armed_q;
    logic [1:0] evt_q;
    logic [1:0] mask_q;
    logic       busy_q;
    logic [2:0] bit_cnt_q;
    logic [7:0] div_q;
    logic       sck_q;
    logic       sck_prev_q;
    logic       out_bit_q;
    logic [2:0] pin_s;
    logic       acc;
    logic       wr;
    logic       rd;
    logic       data_acc;
    logic       data_wr;
    logic       en;
    logic       master;
    logic       tick;
    logic       rise;
    logic       fall;
    logic       done_evt;
    logic       coll_evt;
    logic       start;
    logic       ctrl_wr;
    logic       en_rise;

    sspc_sync #(.W(3)) u_sync (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .async_i ({serial_clock_pin_i, serial_in_pin_i, serial_out_pin_i}),
        .sync_o  (pin_s)
    );

    // bus decode
    assign acc      = cyc_i && stb_i && !ack_o;
    assign wr       = acc && we_i && sel_i[0];
    assign rd       = acc && !we_i;
    assign data_acc = acc && (adr_i == OFS_DATA) && (rd || wr);
    assign data_wr  = wr && (adr_i == OFS_DATA);
    assign ctrl_wr  = wr && (adr_i == OFS_CTRL);
    assign en       = serial_control_q[CTRL_EN_BIT];
    assign master   = serial_control_q[CTRL_MS_BIT];
    assign en_rise  = ctrl_wr && dat_i[CTRL_EN_BIT] && !en;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
        end else begin
            ack_o <= acc;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dat_o <= 32'h0000_0000;
        end else if (rd) begin
            case (adr_i)
                OFS_CTRL: dat_o <= {24'h00_0000, serial_control_q};
                OFS_STAT: dat_o <= {24'h00_0000, transfer_done_flag_q,
                                    access_collision_flag_q, 6'h00};
                OFS_DATA: dat_o <= {24'h00_0000, serial_shift_data_q};
                OFS_PDIR: dat_o <= {24'h00_0000, port_b_direction_reg_q};
                OFS_PDAT: dat_o <= {24'h00_0000, port_b_data_q};
                OFS_PIN:  dat_o <= {24'h00_0000, pin_s, 5'h00};
                OFS_EVT:  dat_o <= {30'h0000_0000, evt_q};
                OFS_MASK: dat_o <= {30'h0000_0000, mask_q};
                default:  dat_o <= 32'h0000_0000;
            endcase
        end
    end

    // control register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            serial_control_q <= CTRL_RST;
        end else if (ctrl_wr) begin
            serial_control_q <= dat_i[7:0];
        end
    end

    // port b direction and data
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            port_b_direction_reg_q <= PB_RST;
        end else if (en_rise) begin
            port_b_direction_reg_q[PB_SDI_BIT] <= 1'b0;
            port_b_direction_reg_q[PB_SDO_BIT] <= 1'b1;
            port_b_direction_reg_q[PB_SCK_BIT] <= dat_i[CTRL_MS_BIT];
        end else if (wr && adr_i == OFS_PDIR) begin
            port_b_direction_reg_q <= {dat_i[7:5], 5'h00};
        end
    end

    // serial function leaves its pin levels in the data register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            port_b_data_q <= PB_RST;
        end else if (wr && adr_i == OFS_PDAT) begin
            port_b_data_q <= {dat_i[7:5], 5'h00};
        end else if (en) begin
            port_b_data_q[PB_SDO_BIT] <= out_bit_q;
            port_b_data_q[PB_SCK_BIT] <= master ? sck_q : pin_s[2];
            port_b_data_q[PB_SDI_BIT] <= pin_s[1];
        end
    end

    // shift clock divider and edges
    assign tick = (div_q == SCK_HALF_TOP);
    assign rise = en && (master ? (tick && busy_q && !sck_q) : (pin_s[2] && !sck_prev_q));
    assign fall = en && (master ? (tick && sck_q) : (!pin_s[2] && sck_prev_q));

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            div_q <= 8'h00;
        end else if (!(busy_q || sck_q) || tick || !en || !master) begin
            div_q <= 8'h00;
        end else begin
            div_q <= div_q + 8'h01;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sck_q      <= 1'b0;
            sck_prev_q <= 1'b0;
        end else begin
            sck_prev_q <= pin_s[2];
            if (!en || !master) begin
                sck_q <= 1'b0;
            end else if (rise || fall) begin
                sck_q <= rise;
            end
        end
    end

    // transfer sequencing
    assign start    = en && master && data_wr && !busy_q;
    assign done_evt = rise && busy_q && (bit_cnt_q == BIT_LAST);
    assign coll_evt = data_acc && busy_q;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            busy_q    <= 1'b0;
            bit_cnt_q <= 3'h0;
        end else if (!en) begin
            busy_q    <= 1'b0;
            bit_cnt_q <= 3'h0;
        end else if (start) begin
            busy_q    <= 1'b1;
            bit_cnt_q <= 3'h0;
        end else if (rise) begin
            busy_q    <= !done_evt;
            bit_cnt_q <= bit_cnt_q + 3'h1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            serial_shift_data_q <= 8'h00;
            out_bit_q           <= 1'b0;
        end else if (data_wr && !busy_q) begin
            serial_shift_data_q <= dat_i[7:0];
            out_bit_q           <= dat_i[7];
        end else if (rise) begin
            serial_shift_data_q <= {serial_shift_data_q[6:0], pin_s[1]};
        end else if (fall || !busy_q) begin
            out_bit_q <= serial_shift_data_q[7];
        end
    end

    // flags; a set in the same cycle wins over the clear
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            clear_armed_q <= 1'b0;
        end else if (rd && adr_i == OFS_STAT) begin
            clear_armed_q <= transfer_done_flag_q;
        end else if (data_acc) begin
            clear_armed_q <= 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            transfer_done_flag_q <= 1'b0;
        end else if (done_evt) begin
            transfer_done_flag_q <= 1'b1;
        end else if (data_acc && clear_armed_q) begin
            transfer_done_flag_q <= 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            access_collision_flag_q <= 1'b0;
        end else if (coll_evt) begin
            access_collision_flag_q <= 1'b1;
        end else if (data_acc && clear_armed_q) begin
            access_collision_flag_q <= 1'b0;
        end
    end

    // interrupt events and mask
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            evt_q <= EVT_RST;
        end else begin
            for (int i = 0; i < 2; i++) begin
                if ((i == EVT_DONE_BIT && done_evt) || (i == EVT_COLL_BIT && coll_evt)) begin
                    evt_q[i] <= 1'b1;
                end else if (wr && adr_i == OFS_EVT && dat_i[i]) begin
                    evt_q[i] <= 1'b0;
                end
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mask_q <= EVT_RST;
            irq_o  <= 1'b0;
        end else begin
            if (wr && adr_i == OFS_MASK) begin
                mask_q <= dat_i[1:0];
            end
            irq_o <= |(evt_q & mask_q);
        end
    end

    // pin drivers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            serial_clock_pin_o    <= 1'b0;
            serial_clock_pin_oe_o <= 1'b0;
            serial_in_pin_o       <= 1'b0;
            serial_in_pin_oe_o    <= 1'b0;
            serial_out_pin_o      <= 1'b0;
            serial_out_pin_oe_o   <= 1'b0;
        end else if (en) begin
            serial_clock_pin_o    <= sck_q;
            serial_clock_pin_oe_o <= master;
            serial_in_pin_o       <= 1'b0;
            serial_in_pin_oe_o    <= 1'b0;
            serial_out_pin_o      <= out_bit_q;
            serial_out_pin_oe_o   <= port_b_direction_reg_q[PB_SDO_BIT];
        end else begin
            serial_clock_pin_o    <= port_b_data_q[PB_SCK_BIT];
            serial_clock_pin_oe_o <= port_b_direction_reg_q[PB_SCK_BIT];
            serial_in_pin_o       <= port_b_data_q[PB_SDI_BIT];
            serial_in_pin_oe_o    <= port_b_direction_reg_q[PB_SDI_BIT];
            serial_out_pin_o      <= port_b_data_q[PB_SDO_BIT];
            serial_out_pin_oe_o   <= port_b_direction_reg_q[PB_SDO_BIT];
        end
    end

    // checks
    a_done_eighth_edge: assert property (@(posedge clk_i) disable iff (rst_i)
        done_evt |=> transfer_done_flag_q && !busy_q && bit_cnt_q == 3'h0)
        else $error("done flag missed eighth edge");

    a_enable_dir_load: assert property (@(posedge clk_i) disable iff (rst_i)
        en_rise |=> !port_b_direction_reg_q[PB_SDI_BIT] && port_b_direction_reg_q[PB_SDO_BIT]
            && port_b_direction_reg_q[PB_SCK_BIT] == master)
        else $error("direction not loaded on enable");

    a_disable_keeps_dir: assert property (@(posedge clk_i) disable iff (rst_i)
        (en && ctrl_wr && !dat_i[CTRL_EN_BIT]) |=> $stable(port_b_direction_reg_q))
        else $error("direction changed on disable");

    a_out_pin_hiz: assert property (@(posedge clk_i) disable iff (rst_i)
        (en && !port_b_direction_reg_q[PB_SDO_BIT]) |=> !serial_out_pin_oe_o)
        else $error("out pin driven with direction zero");

    a_slave_clock_in: assert property (@(posedge clk_i) disable iff (rst_i)
        (en && !master) |=> !serial_clock_pin_oe_o && !serial_in_pin_oe_o)
        else $error("slave drives clock pin");

    a_coll_on_access: assert property (@(posedge clk_i) disable iff (rst_i)
        coll_evt |=> access_collision_flag_q)
        else $error("collision flag not set");

    a_clear_arming: assert property (@(posedge clk_i) disable iff (rst_i)
        (rd && adr_i == OFS_STAT && transfer_done_flag_q) |=> clear_armed_q)
        else $error("status read did not arm clear");

    a_done_clear_seq: assert property (@(posedge clk_i) disable iff (rst_i)
        (data_acc && clear_armed_q && !done_evt) |=> !transfer_done_flag_q)
        else $error("done flag not cleared");

    a_coll_clear_seq: assert property (@(posedge clk_i) disable iff (rst_i)
        (data_acc && clear_armed_q && !coll_evt) |=> !access_collision_flag_q)
        else $error("collision flag not cleared");

    a_write_starts: assert property (@(posedge clk_i) disable iff (rst_i)
        start |=> busy_q && serial_shift_data_q == $past(dat_i[7:0]) ##1 out_bit_q == $past(dat_i[7], 2))
        else $error("write did not start transfer");

    a_flag_no_block: assert property (@(posedge clk_i) disable iff (rst_i)
        (start && transfer_done_flag_q) |=> busy_q)
        else $error("done flag blocked transfer");

    a_shift_in_bit: assert property (@(posedge clk_i) disable iff (rst_i)
        (rise && !(data_wr && !busy_q))
        |=> serial_shift_data_q == {$past(serial_shift_data_q[6:0]), $past(pin_s[1])})
        else $error("shift register did not shift");

    a_master_byte_time: assert property (@(posedge clk_i) disable iff (rst_i)
        (start && SCK_HALF_CYC == 6) |-> ##[90:100] (transfer_done_flag_q || !en))
        else $error("master byte took wrong time");

    a_disabled_plain_io: assert property (@(posedge clk_i) disable iff (rst_i)
        !en |=> serial_out_pin_oe_o == $past(port_b_direction_reg_q[PB_SDO_BIT])
            && serial_out_pin_o == $past(port_b_data_q[PB_SDO_BIT]))
        else $error("pin not plain i/o when disabled");
endmodule

// File: dv/sspc_peer.sv
// serial peripheral model: slave to the block's clock, or clock source for slave mode
`timescale 1ns/100ps
module sspc_peer (
    input  wire logic       sck_i,
    input  wire logic       mosi_i,
    output logic            miso_o,
    output logic            sck_o,
    output logic            sck_oe_o,
    output logic [7:0]      rx_o
);
    logic [7:0] sh_q;

    initial begin
        sh_q = 8'h00;
        rx_o = 8'h00;
        sck_o = 1'b0;
        sck_oe_o = 1'b0;
    end

    // msb first both ways, so the line carries the top bit of the shifter
    assign miso_o = sh_q[7];

    always @(posedge sck_i) begin
        rx_o <= {rx_o[6:0], mosi_i};
    end

    always @(negedge sck_i) begin
        sh_q <= {sh_q[6:0], ~sh_q[7]};
    end

    task automatic load(input logic [7:0] b);
        sh_q = b;
    endtask

    // eight clocks, idle low, the clock stands still between frames
    task automatic run(input realtime half);
        sck_oe_o = 1'b1;
        repeat (8) begin
            #half sck_o = 1'b1;
            #half sck_o = 1'b0;
        end
        sck_oe_o = 1'b0;
    endtask
endmodule

// File: dv/sspc_top_tb.sv
// self-checking bench for the serial port block
`timescale 1ns/100ps
module sspc_top_tb;
    import sspc_pkg::*;
    logic             clk_i = 1'b0;
    logic             rst_i = 1'b1;
    logic             cyc_i = 1'b0;
    logic             stb_i = 1'b0;
    logic             we_i = 1'b0;
    logic [ADR_W-1:0] adr_i = '0;
    logic [3:0]       sel_i = 4'hf;
    logic [31:0]      dat_i = '0;
    logic [31:0]      dat_o;
    logic             ack_o, irq_o, sck_o, sck_oe, sdi_o, sdi_oe, sdo_o, sdo_oe;
    logic             p_miso, p_sck, p_oe, alt_q = 1'b0;
    logic [7:0]       p_rx, b1, b2;
    wire              sck_w = sck_oe ? sck_o : (p_oe ? p_sck : 1'b0);
    wire              sdi_w = sdi_oe ? sdi_o : p_miso;
    wire              sdo_w = sdo_oe ? sdo_o : alt_q;
    logic [15:0]      notes[$];
    logic [15:0]      nt;
    int               n_fail = 0, n_checks = 0, n_edge = 0, n_cyc = 0;

    sspc_top i_dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
        .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
        .irq_o(irq_o), .serial_clock_pin_i(sck_w), .serial_clock_pin_o(sck_o),
        .serial_clock_pin_oe_o(sck_oe), .serial_in_pin_i(sdi_w), .serial_in_pin_o(sdi_o),
        .serial_in_pin_oe_o(sdi_oe), .serial_out_pin_i(sdo_w), .serial_out_pin_o(sdo_o),
        .serial_out_pin_oe_o(sdo_oe));

    sspc_peer i_peer (.sck_i(sck_w), .mosi_i(sdo_w), .miso_o(p_miso), .sck_o(p_sck),
        .sck_oe_o(p_oe), .rx_o(p_rx));

    initial begin
        forever #5 clk_i = ~clk_i;
    end

    // undriven out line shows a changing pattern, not a held value
    always @(posedge clk_i) alt_q <= ~alt_q;
    always @(posedge sck_w) n_edge++;

    task automatic conclude();
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    always @(posedge clk_i) begin
        n_cyc++;
        if (n_cyc == 20000) begin
            n_fail++;
            $display("wrong value at %0t: run did not finish", $time);
            conclude();
        end
    end

    // read results are compared against the oldest note
    always @(posedge clk_i) begin
        if (ack_o === 1'b1) begin
            nt = notes.pop_front();
            if (nt[7:0] != 8'h00) n_checks++;
            if ((dat_o[7:0] & nt[7:0]) !== nt[15:8]) begin
                n_fail++;
                $display("wrong value at %0t: read %h expected %h", $time, dat_o[7:0], nt[15:8]);
            end
        end
    end

    task automatic chk(input bit ok, input string m);
        n_checks++;
        if (!ok) begin
            n_fail++;
            $display("wrong value at %0t: %s", $time, m);
        end
    endtask

    task automatic wb(input logic w, input logic [4:0] a, input logic [7:0] d,
                      input logic [7:0] e, input logic [7:0] m);
        notes.push_back({e & m, m});
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i  <= w;
        adr_i <= a;
        dat_i <= {24'h000000, d};
        @(posedge clk_i);
        while (ack_o !== 1'b1) @(posedge clk_i);
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        we_i  <= 1'b0;
    endtask

    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        wb(1'b1, a, d, 8'h00, 8'h00);
    endtask

    task automatic rd(input logic [4:0] a, input logic [7:0] e, input logic [7:0] m);
        wb(1'b0, a, 8'h00, e, m);
    endtask

    task automatic settle();
        repeat (2) @(posedge clk_i);
        #1;
    endtask

    task automatic wait_irq();
        for (int i = 0; i < 400 && irq_o !== 1'b1; i++) @(posedge clk_i);
        #1;
        chk(irq_o === 1'b1, "interrupt missing after transfer");
    endtask

    initial begin
        void'($urandom(32'hf7f0a7e5));
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(OFS_CTRL, CTRL_RST, 8'hff);
        rd(OFS_PDIR, PB_RST, 8'hff);
        rd(OFS_STAT, 8'h00, 8'hff);
        wr(5'h02, 8'hff);
        rd(5'h02, 8'h00, 8'hff);
        chk({sck_oe, sdi_oe, sdo_oe} === 3'b000, "pins driven after reset");
        // master mode: pins taken, direction loaded
        wr(OFS_CTRL, 8'h50);
        rd(OFS_PDIR, 8'ha0, 8'he0);
        settle();
        chk({sck_oe, sdi_oe, sdo_oe} === 3'b101, "master pin drive");
        wr(OFS_MASK, 8'h01);
        b1 = 8'($urandom());
        b2 = 8'($urandom());
        i_peer.load(b2);
        n_edge = 0;
        wr(OFS_DATA, b1);
        rd(OFS_DATA, 8'h00, 8'h00);
        wr(OFS_DATA, ~b1);
        wait_irq();
        chk(n_edge == 8, "clock edge count");
        chk(p_rx === b1, "byte at peer");
        wr(OFS_EVT, 8'h01);
        settle();
        chk(irq_o === 1'b0, "interrupt not cleared");
        // second transfer with the done flag still set
        b1 = 8'($urandom());
        i_peer.load(8'h3c);
        wr(OFS_DATA, b1);
        wait_irq();
        chk(p_rx === b1, "second byte at peer");
        rd(OFS_STAT, 8'hc0, 8'hc0);
        rd(OFS_DATA, 8'h3c, 8'hff);
        rd(OFS_STAT, 8'h00, 8'hc0);
        wr(OFS_MASK, 8'h00);
        settle();
        chk(irq_o === 1'b0, "masked interrupt raised");
        wr(OFS_EVT, 8'h03);
        rd(OFS_EVT, 8'h00, 8'h03);
        wr(OFS_PDIR, 8'h80);
        settle();
        chk(sdo_oe === 1'b0, "out pin still driven");
        wr(OFS_PDIR, 8'ha0);
        wr(OFS_CTRL, 8'h00);
        rd(OFS_PDIR, 8'ha0, 8'he0);
        settle();
        chk(sck_oe === 1'b1, "plain i/o direction lost");
        wr(OFS_PDIR, 8'he0);
        wr(OFS_PDAT, 8'ha0);
        settle();
        chk({sck_oe, sdi_oe, sdo_oe, sck_o, sdi_o, sdo_o} === 6'b111101, "plain i/o output");
        rd(OFS_PIN, 8'ha0, 8'he0);
        // slave mode, clock from the peer
        wr(OFS_CTRL, 8'h40);
        rd(OFS_PDIR, 8'h20, 8'he0);
        settle();
        chk(sck_oe === 1'b0, "slave drives clock");
        b1 = 8'($urandom());
        b2 = 8'($urandom());
        wr(OFS_MASK, 8'h01);
        wr(OFS_DATA, b1);
        i_peer.load(b2);
        @(posedge clk_i);
        #3;
        i_peer.run(62.5);
        wait_irq();
        chk(p_rx === b1, "slave byte at peer");
        rd(OFS_STAT, 8'h80, 8'h80);
        rd(OFS_DATA, b2, 8'hff);
        conclude();
    end
endmodule
